// [verilog/spi_flash_protocol_protect.sv]
// Serial nonvolatile memory: command decode, array, protection
`timescale 1ns/1ps
`default_nettype none
module spi_flash_protocol_protect #(
   parameter int ADDR_W = flash_pkg::ADDR_W_DEF,
   parameter int PROG_CYCLES = flash_pkg::PROG_CYCLES
) (
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic SI,
   input wire logic HOLD_N,
   input wire logic PROGRAM_PROTECT_PIN_N,
   output logic SO,
   output logic SO_OE,
   output logic BUSY,
   output logic [7:0] STATUS
);
   import flash_pkg::*;

   // Link side (SCK domain)
   logic cs_clr;
   logic start_r;
   logic [8:0] bits_r;
   logic [8:0] bits_now;
   logic [2:0] ph_r;
   logic [2:0] ph_now;
   logic [7:0] shift_r;
   logic [7:0] shift_nxt;
   logic [7:0] opcode_r;
   logic [15:0] addr_r;
   logic [ADDR_W-1:0] addr_inc;
   logic [7:0] srdat_r;
   logic [PAGE_W-1:0] pofs_r;
   logic [7:0] page_r [PAGE_BYTES];
   logic [7:0] sr_m_r;
   logic [7:0] sr_s_r;
   logic [7:0] out_sh_r;
   logic so_oe_r;
   logic rd_hdr;
   logic sr_hdr;

   // Core side (MCLK domain)
   logic [7:0] mem [2**ADDR_W];
   logic cs_m_r, cs_s_r, cs_d_r;
   logic prot_m_r, prot_s_r, prot_d_r;
   logic cs_rise, cs_fall;
   logic hw_prot;
   logic prot_abort_r;
   logic wel_r;
   nv_status_t nv_r;
   nv_status_t nv_new_r;
   pstate_t st_r;
   logic [CNT_W-1:0] tmr_r;
   logic [PAGE_W-1:0] cp_r;
   logic [ADDR_W-PAGE_W-1:0] sec_r;
   logic take, locked;
   logic do_set, do_clr, do_sprog, do_aprog, done;
   logic [7:0] stat_r;
   logic [7:0] stat_nxt;

   assign cs_clr = CS_N | ~ARST_N;
   assign shift_nxt = {shift_r[6:0], SI};
   assign bits_now = start_r ? 9'h001 : (bits_r == BITS_MAX ? bits_r : bits_r + 9'h001);
   assign ph_now = start_r ? 3'h1 : ph_r + 3'h1;
   assign addr_inc = addr_r[ADDR_W-1:0] + 1'b1;

   // New frame marker, set while deselected
   always_ff @(posedge SCK or posedge cs_clr) begin
      if (cs_clr) begin
         start_r <= 1'b1;
      end else if (HOLD_N) begin
         start_r <= 1'b0;
      end
   end

   // Input shifting and header capture on the rising edge
   always_ff @(posedge SCK or negedge ARST_N) begin
      if (!ARST_N) begin
         bits_r <= 9'h000;
         ph_r <= 3'h0;
         shift_r <= 8'h00;
         opcode_r <= 8'h00;
         addr_r <= 16'h0000;
         srdat_r <= 8'h00;
         pofs_r <= '0;
      end else if (HOLD_N) begin
         bits_r <= bits_now;
         ph_r <= ph_now;
         shift_r <= shift_nxt;
         if (bits_now == OPCODE_BITS) begin
            opcode_r <= shift_nxt;
         end
         if (opcode_r == status_program_cmd && bits_now == SPROG_BITS) begin
            srdat_r <= shift_nxt;
         end
         if (bits_now == ADDR_HI_BITS) begin
            addr_r[15:8] <= shift_nxt;
         end
         if (bits_now == HEADER_BITS) begin
            addr_r[7:0] <= shift_nxt;
            pofs_r <= shift_nxt[PAGE_W-1:0];
         end
         if (opcode_r == read_cmd && bits_now > HEADER_BITS && ph_now == 3'h0) begin
            addr_r <= 16'(addr_inc);
         end
         if (opcode_r == program_cmd && bits_now > HEADER_BITS && ph_now == 3'h0) begin
            pofs_r <= pofs_r + 1'b1;
         end
      end
   end

   // Sector buffer, filled byte by byte within one sector
   always_ff @(posedge SCK) begin
      if (HOLD_N && opcode_r == program_cmd && bits_now > HEADER_BITS && ph_now == 3'h0) begin
         page_r[pofs_r] <= shift_nxt;
      end
   end

   // Status byte into the link domain
   always_ff @(posedge SCK or negedge ARST_N) begin
      if (!ARST_N) begin
         sr_m_r <= 8'h00;
         sr_s_r <= 8'h00;
      end else begin
         sr_m_r <= stat_r;
         sr_s_r <= sr_m_r;
      end
   end

   assign rd_hdr = !start_r && opcode_r == read_cmd && bits_r >= HEADER_BITS;
   assign sr_hdr = !start_r && opcode_r == status_read_cmd && bits_r >= OPCODE_BITS;

   // Output shifting on the falling edge
   always_ff @(negedge SCK or posedge cs_clr) begin
      if (cs_clr) begin
         out_sh_r <= 8'h00;
         so_oe_r <= 1'b0;
      end else if (HOLD_N) begin
         if (ph_r == 3'h0 && rd_hdr) begin
            out_sh_r <= mem[addr_r[ADDR_W-1:0]];
            so_oe_r <= 1'b1;
         end else if (ph_r == 3'h0 && sr_hdr) begin
            out_sh_r <= sr_s_r;
            so_oe_r <= 1'b1;
         end else begin
            out_sh_r <= {out_sh_r[6:0], 1'b0};
         end
      end
   end

   assign SO = out_sh_r[7];
   assign SO_OE = so_oe_r & HOLD_N;

   // Pin synchronisers in the core domain
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cs_m_r <= 1'b1;
         cs_s_r <= 1'b1;
         cs_d_r <= 1'b1;
         prot_m_r <= 1'b1;
         prot_s_r <= 1'b1;
         prot_d_r <= 1'b1;
      end else begin
         cs_m_r <= CS_N;
         cs_s_r <= cs_m_r;
         cs_d_r <= cs_s_r;
         prot_m_r <= PROGRAM_PROTECT_PIN_N;
         prot_s_r <= prot_m_r;
         prot_d_r <= prot_s_r;
      end
   end

   assign cs_rise = cs_s_r & ~cs_d_r;
   assign cs_fall = ~cs_s_r & cs_d_r;
   assign hw_prot = nv_r.protect_pin_enable_bit & ~prot_s_r;

   // Link registers are still while deselected, so read them at the rise
   always_comb begin
      case (nv_r.bl)
         BL_NONE: locked = 1'b0;
         BL_QUARTER: locked = &addr_r[ADDR_W-1:ADDR_W-2];
         BL_HALF: locked = addr_r[ADDR_W-1];
         BL_ALL: locked = 1'b1;
         default: locked = 1'b1;
      endcase
   end

   assign take = cs_rise && st_r == ST_IDLE;
   assign do_set = take && opcode_r == latch_set_cmd && bits_r == OPCODE_BITS;
   assign do_clr = take && opcode_r == latch_clear_cmd && bits_r == OPCODE_BITS;
   assign do_sprog = take && opcode_r == status_program_cmd && bits_r == SPROG_BITS
      && wel_r && !hw_prot && !prot_abort_r;
   assign do_aprog = take && opcode_r == program_cmd && bits_r == PROG_BITS
      && wel_r && !locked;
   assign done = (st_r == ST_ARRAY || st_r == ST_STATUS) && tmr_r == '0;

   // Protect pin falling during a selected frame
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         prot_abort_r <= 1'b0;
      end else if (prot_d_r && !prot_s_r && !cs_s_r && nv_r.protect_pin_enable_bit) begin
         prot_abort_r <= 1'b1;
      end else if (cs_fall) begin
         prot_abort_r <= 1'b0;
      end
   end

   // Write-enable latch
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wel_r <= 1'b0;
      end else if (do_set) begin
         wel_r <= 1'b1;
      end else if (do_clr || done) begin
         wel_r <= 1'b0;
      end
   end

   // Nonvolatile status bits, committed at the end of the cycle
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         nv_r <= '{protect_pin_enable_bit: PIN_EN_RST, bl: BL_RST};
         nv_new_r <= '{protect_pin_enable_bit: PIN_EN_RST, bl: BL_RST};
      end else begin
         if (do_sprog) begin
            nv_new_r <= '{protect_pin_enable_bit: srdat_r[SR_PIN_EN],
               bl: srdat_r[SR_BL_HI:SR_BL_LO]};
         end
         if (done && st_r == ST_STATUS) begin
            nv_r <= nv_new_r;
         end
      end
   end

   // Self-timed program sequencer
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_r <= ST_IDLE;
         tmr_r <= '0;
         cp_r <= '0;
         sec_r <= '0;
      end else begin
         case (st_r)
            ST_IDLE: begin
               if (do_aprog) begin
                  st_r <= ST_COPY;
                  cp_r <= '0;
                  sec_r <= addr_r[ADDR_W-1:PAGE_W];
               end else if (do_sprog) begin
                  st_r <= ST_STATUS;
                  tmr_r <= CNT_W'(PROG_CYCLES - 1);
               end
            end
            ST_COPY: begin
               cp_r <= cp_r + 1'b1;
               if (&cp_r) begin
                  st_r <= ST_ARRAY;
                  tmr_r <= CNT_W'(PROG_CYCLES - 1);
               end
            end
            ST_ARRAY, ST_STATUS: begin
               if (tmr_r == '0) begin
                  st_r <= ST_IDLE;
               end else begin
                  tmr_r <= tmr_r - 1'b1;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // Array write port
   always_ff @(posedge MCLK) begin
      if (st_r == ST_COPY) begin
         mem[{sec_r, cp_r}] <= page_r[cp_r];
      end
   end

   // Status byte as seen by the host
   always_comb begin
      stat_nxt = 8'h00;
      stat_nxt[SR_PIN_EN] = nv_r.protect_pin_enable_bit;
      stat_nxt[SR_BL_HI:SR_BL_LO] = nv_r.bl;
      stat_nxt[SR_WEL] = wel_r;
      if (st_r != ST_IDLE) begin
         stat_nxt = STATUS_BUSY_VAL;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         stat_r <= 8'h00;
      end else begin
         stat_r <= stat_nxt;
      end
   end

   assign STATUS = stat_r;
   assign BUSY = stat_r[SR_WIP];

   latch_set_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
      do_set |-> ##2 STATUS[SR_WEL])
      else $error("latch not set by set opcode");

   latch_clear_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
      do_clr |=> !wel_r ##1 !STATUS[SR_WEL])
      else $error("latch not cleared by clear opcode");

   exact_count_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (take && opcode_r == program_cmd && bits_r != PROG_BITS) |=> st_r == ST_IDLE)
      else $error("array program started on wrong bit count");

   hw_block_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (take && hw_prot) |=> st_r != ST_STATUS)
      else $error("status program while hardware protected");

   lock_all_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (take && nv_r.bl == BL_ALL) |=> st_r != ST_COPY)
      else $error("array program in fully locked array");

   busy_flag_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (st_r != ST_IDLE) |=> STATUS == STATUS_BUSY_VAL)
      else $error("busy not reported during program");

   done_latch_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
      done |=> !wel_r && st_r == ST_IDLE)
      else $error("latch still set after program cycle");

   deselect_off_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
      CS_N |-> !SO_OE)
      else $error("serial output driven while deselected");

   pin_abort_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (take && prot_abort_r) |=> st_r != ST_STATUS)
      else $error("status program survived protect pin fall");

   read_wrap_a: assert property (@(posedge SCK) disable iff (!ARST_N)
      (HOLD_N && !start_r && opcode_r == read_cmd && bits_r > HEADER_BITS
       && ph_r == 3'h7) |=> addr_r == 16'($past(addr_inc)))
      else $error("read address did not advance");
endmodule : spi_flash_protocol_protect
`default_nettype wire

// [verilog/flash_pkg.sv]
// Constants and types for the serial nonvolatile command and protect block
package flash_pkg;
   localparam logic [7:0] latch_set_cmd = 8'h06;
   localparam logic [7:0] latch_clear_cmd = 8'h04;
   localparam logic [7:0] status_read_cmd = 8'h05;
   localparam logic [7:0] status_program_cmd = 8'h01;
   localparam logic [7:0] read_cmd = 8'h03;
   localparam logic [7:0] program_cmd = 8'h02;

   // Bit counts within a frame
   localparam logic [8:0] OPCODE_BITS = 9'h008;
   localparam logic [8:0] ADDR_HI_BITS = 9'h010;
   localparam logic [8:0] HEADER_BITS = 9'h018;
   localparam logic [8:0] SPROG_BITS = 9'h010;
   localparam logic [8:0] PROG_BITS = 9'h118;
   localparam logic [8:0] BITS_MAX = 9'h1ff;
   localparam int PAGE_BYTES = 32;
   localparam int PAGE_W = 5;

   // Status register field positions
   localparam int SR_PIN_EN = 7;
   localparam int SR_BL_HI = 3;
   localparam int SR_BL_LO = 2;
   localparam int SR_WEL = 1;
   localparam int SR_WIP = 0;
   localparam logic [7:0] STATUS_BUSY_VAL = 8'hff;

   // Lock codes
   localparam logic [1:0] BL_NONE = 2'h0;
   localparam logic [1:0] BL_QUARTER = 2'h1;
   localparam logic [1:0] BL_HALF = 2'h2;
   localparam logic [1:0] BL_ALL = 2'h3;

   // Reset values
   localparam logic PIN_EN_RST = 1'b0;
   localparam logic [1:0] BL_RST = 2'h0;

   // Timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int PROG_TIME_US = 10000;
   localparam int PROG_CYCLES = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int CNT_W = 22;
   localparam int ADDR_W_DEF = 13;

   typedef struct packed {
      logic protect_pin_enable_bit;
      logic [1:0] bl;
   } nv_status_t;

   typedef enum {ST_IDLE, ST_COPY, ST_ARRAY, ST_STATUS} pstate_t;
endpackage : flash_pkg

// [testbench/spi_host.sv]
// Host controller model that drives frames on the serial link
`timescale 1ns/1ps
`default_nettype none
module spi_host (
   output wire logic sck,
   output var logic cs_n,
   output var logic si,
   output var logic hold_n,
   input wire logic so,
   input wire logic so_oe
);
   logic lclk = 1'b0;
   logic run = 1'b0;
   logic hold_oe = 1'b0;

   // Link clock free runs inside, reaches the pin only within frames
   initial begin
      cs_n = 1'b1;
      si = 1'b0;
      hold_n = 1'b1;
      #1.3;
      forever #16 lclk = ~lclk;
   end
   assign sck = lclk & run;

   task automatic frame(input int n, input logic [287:0] tx, input int hold_at,
                        output logic [287:0] rx);
      rx = '0;
      @(negedge lclk);
      cs_n <= 1'b0;
      si <= tx[n - 1];
      @(negedge lclk);
      run <= 1'b1;
      for (int i = 1; i <= n; i++) begin
         @(posedge lclk);
         // Undriven line reads as the inverse of its last level
         rx = {rx[286:0], so_oe ? so : ~so};
         @(negedge lclk);
         if (i < n) begin
            si <= tx[n - 1 - i];
         end else begin
            run <= 1'b0;
         end
         if (i == hold_at) begin
            hold_n <= 1'b0;
            repeat (3) begin
               @(posedge lclk);
               hold_oe = hold_oe | so_oe;
               @(negedge lclk);
               si <= ~si;
            end
            @(negedge lclk);
            hold_n <= 1'b1;
            si <= tx[n - 1 - i];
         end
      end
      @(negedge lclk);
      cs_n <= 1'b1;
      si <= ~si;
      repeat (2) @(negedge lclk);
   endtask : frame
endmodule : spi_host
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the serial memory command and protect block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import flash_pkg::*;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic prot_n = 1'b1;
   wire logic sck, cs_n, si, hold_n, so, so_oe, busy;
   wire logic [7:0] status;
   int bad_count = 0;
   int checked = 0;
   logic [287:0] rx;

   always #2 mclk = ~mclk;

   spi_host u_host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));
   spi_flash_protocol_protect #(.ADDR_W(13), .PROG_CYCLES(200)) u_dut (.MCLK(mclk),
      .ARST_N(arst_n), .SCK(sck), .CS_N(cs_n), .SI(si), .HOLD_N(hold_n),
      .PROGRAM_PROTECT_PIN_N(prot_n), .SO(so), .SO_OE(so_oe), .BUSY(busy), .STATUS(status));

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic frame(input int n, input logic [287:0] tx, input int hold_at = 0);
      u_host.frame(n, tx, hold_at, rx);
   endtask : frame

   function automatic logic [7:0] pat(input logic [15:0] base, input int i);
      return base[12:5] ^ 8'(i) ^ 8'h5a;
   endfunction : pat

   function automatic logic [287:0] ptx(input logic [15:0] base);
      logic [287:0] t;
      t = {8'h00, program_cmd, base, 256'h0};
      for (int i = 0; i < 32; i++) begin
         t[255 - 8 * i -: 8] = pat(base, i);
      end
      return t;
   endfunction : ptx

   task automatic rd_status(input logic [7:0] exp);
      frame(16, 288'({status_read_cmd, 8'h00}));
      check("status", rx[7:0], exp);
   endtask : rd_status

   task automatic wait_idle();
      int k;
      k = 0;
      while (busy !== 1'b0) begin
         @(posedge mclk);
         k++;
         if (k > 2000) begin
            bad_count++;
            end_of_test();
         end
      end
   endtask : wait_idle

   task automatic prog_op(input int n, input logic [287:0] tx, input logic ok,
                          input logic [7:0] sr, input bit pulse = 1'b0);
      frame(8, 288'(latch_set_cmd));
      fork
         frame(n, tx);
         if (pulse) begin
            repeat (60) @(posedge mclk);
            prot_n <= 1'b0;
            repeat (20) @(posedge mclk);
            prot_n <= 1'b1;
         end
      join
      check("busy", {7'h0, busy}, {7'h0, ok});
      if (ok) begin
         rd_status(8'hff);
         wait_idle();
         rd_status(sr);
         check("status_pins", status, sr);
      end else begin
         rd_status(sr | 8'h02);
         check("status_pins", status, sr | 8'h02);
         frame(8, 288'(latch_clear_cmd));
         rd_status(sr);
      end
   endtask : prog_op

   task automatic read_wrap();
      logic [7:0] e;
      frame(288, {read_cmd, 16'hffff, 264'h0}, 100);
      check("pause_oe", {7'h0, u_host.hold_oe}, 8'h00);
      check("so_oe", {7'h0, so_oe}, 8'h00);
      for (int j = 0; j < 33; j++) begin
         e = (j == 0) ? pat(16'h1fe0, 31) : pat(16'h0000, j - 1);
         check("read", rx[263 - 8 * j -: 8], e);
      end
   endtask : read_wrap

   initial begin
      repeat (16) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      check("so_oe", {7'h0, so_oe}, 8'h00);
      check("status_pins", status, 8'h00);
      rd_status(8'h00);
      frame(8, 288'(latch_set_cmd));
      rd_status(8'h02);
      frame(8, 288'(latch_clear_cmd));
      rd_status(8'h00);
      frame(16, 288'({latch_set_cmd, program_cmd}));
      rd_status(8'h00);
      prog_op(280, ptx(16'h0000), 1'b1, 8'h00);
      prog_op(280, ptx(16'h1fe0), 1'b1, 8'h00);
      prog_op(279, ptx(16'h0020) >> 1, 1'b0, 8'h00);
      read_wrap();
      prog_op(16, 288'({status_program_cmd, 8'h8c}), 1'b1, 8'h8c);
      prog_op(280, ptx(16'h0040), 1'b0, 8'h8c);
      @(posedge mclk);
      prot_n <= 1'b0;
      prog_op(16, 288'({status_program_cmd, 8'h04}), 1'b0, 8'h8c);
      @(posedge mclk);
      prot_n <= 1'b1;
      prog_op(16, 288'({status_program_cmd, 8'h04}), 1'b0, 8'h8c, 1'b1);
      prog_op(16, 288'({status_program_cmd, 8'h04}), 1'b1, 8'h04);
      prog_op(280, ptx(16'h1fe0), 1'b0, 8'h04);
      prog_op(280, ptx(16'h1000), 1'b1, 8'h04);
      @(posedge mclk);
      prot_n <= 1'b0;
      prog_op(16, 288'({status_program_cmd, 8'h00}), 1'b1, 8'h00);
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
